// File: logic/servo_protection_monitor.sv
// servo protection monitor: error detection, torque clamp, register slave
// assumes feedback inputs synchronous to clock and an AXI4-Lite master
`timescale 1ns/1ns

// How it works
// RQ1 - over-speed error 26.0 when speed magnitude exceeds over-speed level
// RQ2 - over-speed level resets to the motor type default
// RQ3 - software sets over-speed level to max speed times 1.2 to 1.5
// RQ4 - position or full-closed mode: error 24.0 on excess deviation
// RQ5 - unit select 0 compares command deviation, 1 encoder or scale
// RQ6 - software sets excess level from max frequency over smallest gain
// RQ7 - position mode: error 34.0 when revolutions exceed working range
// RQ8 - full-closed: error 25.0 when motor and load positions drift apart
// RQ9 - enable bit 7 set: inhibit input during Z return gives 94.3, cut
// RQ10 - enable bit 7 clear: inhibit inputs ignored during Z return; the torque block still acts on them
// RQ11 - software selects limit 0 or 1 for one uniform torque limit
// RQ12 - torque in-limit output high while command is clamped
// RQ13 - Z home position should sit well away from the inhibit sensors
// RQ14 - positive inhibit blocks positive drive, negative blocks negative
// RQ15 - checks run once per control cycle, error held until alarm clear
module servo_protection_monitor
  import servo_protection_pkg::*;
#(
  parameter int unsigned CYCLE_COUNT     = CONTROL_CYCLES,
  parameter logic [31:0] MOTOR_OVERSPEED = OVERSPEED_DEFAULT
)(
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output wire logic               awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output wire logic               wready,
  output logic      [1:0]         bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output wire logic               arready,
  output logic      [31:0]        rdata,
  output logic      [1:0]         rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire control_mode_type   control_mode,
  input  wire feedback_type       feedback,
  input  wire logic               homing_z_return,
  input  wire logic               pos_travel_inhibit,
  input  wire logic               neg_travel_inhibit,
  input  wire logic signed [15:0] torque_command,
  output logic signed [15:0]      torque_out,
  output logic                    torque_in_limit_out,
  output wire logic               current_off,
  output error_code_type          error_code,
  output wire logic               irq
);

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] new_data,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = strb[i] ? new_data[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction

  // software registers
  logic        [31:0] overspeed_level;
  logic        [31:0] deviation_excess_level;
  logic               deviation_unit_select;
  logic        [31:0] working_range_revs;
  logic        [31:0] hybrid_deviation_level;
  logic        [15:0] comm_extended_setup_1;
  logic        [15:0] torque_limit_level_1;
  logic        [15:0] torque_limit_select;
  logic        [15:0] torque_limit_level_2;
  logic [EV_W-1:0]    irq_status;
  logic [EV_W-1:0]    irq_mask;

  // write channel holding registers
  logic               aw_held;
  logic               w_held;
  logic        [7:0]  aw_addr;
  logic        [31:0] w_data;
  logic        [3:0]  w_strb;

  // write address and data taken in either order, one write at a time
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  wire write_go  = aw_held && w_held && !bvalid;

  always_ff @(posedge clock) begin
    if (reset) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (write_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (write_go) begin
      w_held <= 1'b0;
    end
  end

  // write decode
  wire wr_control  = write_go && aw_addr == OFF_CONTROL;
  wire wr_speed    = write_go && aw_addr == OFF_OVERSPEED;
  wire wr_dev      = write_go && aw_addr == OFF_DEV_EXCESS;
  wire wr_unit     = write_go && aw_addr == OFF_DEV_UNIT;
  wire wr_range    = write_go && aw_addr == OFF_RANGE_REVS;
  wire wr_hybrid   = write_go && aw_addr == OFF_HYBRID_DEV;
  wire wr_comm     = write_go && aw_addr == OFF_COMM_EXT_1;
  wire wr_tq1      = write_go && aw_addr == OFF_TQ_LEVEL_1;
  wire wr_tqsel    = write_go && aw_addr == OFF_TQ_SELECT;
  wire wr_tq2      = write_go && aw_addr == OFF_TQ_LEVEL_2;
  wire wr_status   = write_go && aw_addr == OFF_IRQ_STATUS;
  wire wr_mask     = write_go && aw_addr == OFF_IRQ_MASK;
  wire wr_error    = write_go && aw_addr == OFF_ERROR;
  wire wr_mapped   = wr_control || wr_speed || wr_dev || wr_unit ||
                     wr_range || wr_hybrid || wr_comm || wr_tq1 ||
                     wr_tqsel || wr_tq2 || wr_status || wr_mask || wr_error;
  wire [31:0] wr_bits = merge(32'h0000_0000, w_data, w_strb);
  wire alarm_clear    = wr_control && wr_bits[ALARM_CLEAR_BIT];

  // write response, slave error on an unmapped address
  always_ff @(posedge clock) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (write_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // threshold registers; over-speed starts at the motor default
  always_ff @(posedge clock) begin
    if (reset) begin
      overspeed_level        <= MOTOR_OVERSPEED; // [RQ2]
      deviation_excess_level <= DEV_EXCESS_RESET;
      deviation_unit_select  <= 1'b0;
      working_range_revs     <= RANGE_REVS_RESET;
      hybrid_deviation_level <= HYBRID_DEV_RESET;
    end else begin
      if (wr_speed) overspeed_level <= merge(overspeed_level, w_data, w_strb);
      if (wr_dev) deviation_excess_level <=
        merge(deviation_excess_level, w_data, w_strb);
      if (wr_unit && w_strb[0]) deviation_unit_select <= w_data[0];
      if (wr_range) working_range_revs <=
        merge(working_range_revs, w_data, w_strb);
      if (wr_hybrid) hybrid_deviation_level <=
        merge(hybrid_deviation_level, w_data, w_strb);
    end
  end

  // setup, torque limit and interrupt mask registers, low half-word only
  always_ff @(posedge clock) begin
    if (reset) begin
      comm_extended_setup_1 <= 16'h0000;
      torque_limit_level_1  <= TQ_LEVEL_RESET;
      torque_limit_select   <= TQ_SELECT_RESET;
      torque_limit_level_2  <= TQ_LEVEL_RESET;
      irq_mask              <= '0;
    end else begin
      if (wr_comm) comm_extended_setup_1 <=
        16'(merge({16'h0000, comm_extended_setup_1}, w_data, w_strb));
      if (wr_tq1) torque_limit_level_1 <=
        16'(merge({16'h0000, torque_limit_level_1}, w_data, w_strb));
      if (wr_tqsel) torque_limit_select <=
        16'(merge({16'h0000, torque_limit_select}, w_data, w_strb));
      if (wr_tq2) torque_limit_level_2 <=
        16'(merge({16'h0000, torque_limit_level_2}, w_data, w_strb));
      if (wr_mask) irq_mask <= wr_bits[EV_W-1:0];
    end
  end

  // control cycle divider; the protection checks are sampled on its tick, the torque clamp runs every clock
  logic [15:0] cycle_count;
  wire tick = cycle_count == 16'(CYCLE_COUNT - 1);

  always_ff @(posedge clock) begin
    if (reset || tick) begin
      cycle_count <= 16'h0000;
    end else begin
      cycle_count <= cycle_count + 16'h0001;
    end
  end

  // mode qualifiers and compared quantities
  wire mode_pos    = control_mode == MODE_POSITION;
  wire mode_full   = control_mode == MODE_FULL_CLOSED;
  wire signed [31:0] dev_selected = deviation_unit_select ?
    feedback.dev_encoder : feedback.dev_command; // [RQ5]
  wire signed [31:0] hybrid_gap =
    feedback.motor_position - feedback.load_position;
  wire homing_enable = comm_extended_setup_1[HOMING_OT_BIT];

  wire trip_speed;
  wire trip_dev;
  wire trip_range;
  wire trip_hybrid;

  level_check speed_check (
    .enable  (1'b1),
    .value   (feedback.speed),
    .level   (overspeed_level),
    .exceeds (trip_speed)   // [RQ1]
  );

  level_check dev_check (
    .enable  (mode_pos || mode_full),
    .value   (dev_selected),
    .level   (deviation_excess_level),
    .exceeds (trip_dev)     // [RQ4]
  );

  level_check range_check (
    .enable  (mode_pos),
    .value   (feedback.motor_revs),
    .level   (working_range_revs),
    .exceeds (trip_range)   // [RQ7]
  );

  level_check hybrid_check (
    .enable  (mode_full),
    .value   (hybrid_gap),
    .level   (hybrid_deviation_level),
    .exceeds (trip_hybrid)  // [RQ8]
  );

  // inhibit inputs only raise the homing trip in Z return when enabled [RQ9] [RQ10]
  wire trip_homing = homing_enable && homing_z_return &&
                     (pos_travel_inhibit || neg_travel_inhibit);
  wire any_trip    = trip_homing || trip_speed || trip_hybrid ||
                     trip_dev || trip_range;

  // fixed priority: homing, speed, hybrid, deviation, range
  wire [7:0] trip_main = trip_homing ? ERR_HOMING_MAIN :
                         trip_speed  ? ERR_SPEED_MAIN  :
                         trip_hybrid ? ERR_HYBRID_MAIN :
                         trip_dev    ? ERR_DEV_MAIN    : ERR_RANGE_MAIN;
  wire [3:0] trip_sub  = trip_homing ? ERR_HOMING_SUB : ERR_SUB_ZERO;

  // first error latched and held; a trip in the clear cycle still lands
  always_ff @(posedge clock) begin
    if (reset) begin
      error_code <= '0;
    end else if (tick && any_trip && (!error_code.valid || alarm_clear)) begin
      error_code <= '{1'b1, trip_main, trip_sub}; // [RQ15]
    end else if (alarm_clear) begin
      error_code <= '0; // [RQ15]
    end
  end

  // any held alarm removes motor current
  assign current_off = error_code.valid; // [RQ9]

  // torque clamp; select above 1 gives level 2 on the negative side
  wire signed [15:0] limit_pos = $signed(torque_limit_level_1);
  wire signed [15:0] limit_neg = (torque_limit_select <= 16'h0001) ?
    limit_pos : $signed(torque_limit_level_2);
  wire clamp_pos = torque_command > limit_pos;
  wire clamp_neg = torque_command < -limit_neg;
  wire block_pos = pos_travel_inhibit && torque_command > 16'sh0000;
  wire block_neg = neg_travel_inhibit && torque_command < 16'sh0000;
  wire signed [15:0] next_torque =
    (current_off || block_pos || block_neg) ? 16'sh0000 : // [RQ14]
    clamp_pos ? limit_pos :
    clamp_neg ? -limit_neg : torque_command;

  always_ff @(posedge clock) begin
    if (reset) begin
      torque_out          <= 16'sh0000;
      torque_in_limit_out <= 1'b0;
    end else begin
      torque_out          <= next_torque;
      torque_in_limit_out <= clamp_pos || clamp_neg; // [RQ12]
    end
  end

  // sticky events, write one to clear, a new event beats the clear
  wire tlc_rise = (clamp_pos || clamp_neg) && !torque_in_limit_out;
  wire [EV_W-1:0] events = {tlc_rise, {tick, tick, tick, tick, tick} &
    {trip_homing, trip_hybrid, trip_range, trip_dev, trip_speed}};
  wire [EV_W-1:0] clear_bits = wr_status ? wr_bits[EV_W-1:0] : '0;

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~clear_bits) | events;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read decode; unmapped reads give zero with a slave error
  wire rd_mapped = araddr <= OFF_IRQ_MASK && araddr[1:0] == 2'h0;
  wire [31:0] read_word =
    araddr == OFF_OVERSPEED  ? overspeed_level :
    araddr == OFF_DEV_EXCESS ? deviation_excess_level :
    araddr == OFF_DEV_UNIT   ? {31'h0, deviation_unit_select} :
    araddr == OFF_RANGE_REVS ? working_range_revs :
    araddr == OFF_HYBRID_DEV ? hybrid_deviation_level :
    araddr == OFF_COMM_EXT_1 ? {16'h0000, comm_extended_setup_1} :
    araddr == OFF_TQ_LEVEL_1 ? {16'h0000, torque_limit_level_1} :
    araddr == OFF_TQ_SELECT  ? {16'h0000, torque_limit_select} :
    araddr == OFF_TQ_LEVEL_2 ? {16'h0000, torque_limit_level_2} :
    araddr == OFF_ERROR      ? {15'h0000, error_code.valid,
                                4'h0, error_code.main, error_code.sub} :
    araddr == OFF_IRQ_STATUS ? {26'h0, irq_status} :
    araddr == OFF_IRQ_MASK   ? {26'h0, irq_mask} : 32'h0000_0000;

  assign arready = !rvalid;

  always_ff @(posedge clock) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= read_word;
      rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // checks on the design's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  wire idle_tick = tick && !error_code.valid;

  sequence homing_hit;
    idle_tick && trip_homing;
  endsequence

  sequence drive_cut;
    error_code.main == ERR_HOMING_MAIN && error_code.sub == ERR_HOMING_SUB
      && current_off ##1 torque_out == 16'sh0000;
  endsequence

  speed_trip_a: assert property ( // [RQ1]
    idle_tick && !trip_homing &&
      magnitude(feedback.speed) > overspeed_level
    |=> error_code.valid && error_code.main == ERR_SPEED_MAIN)
    else $error("over-speed not raised");

  speed_default_a: assert property ( // [RQ2]
    $fell(reset) |-> overspeed_level == MOTOR_OVERSPEED)
    else $error("over-speed level not at motor default");

  dev_trip_a: assert property ( // [RQ4]
    idle_tick && (mode_pos || mode_full) && !trip_homing && !trip_speed &&
      !trip_hybrid && !deviation_unit_select &&
      magnitude(feedback.dev_command) > deviation_excess_level
    |=> error_code.main == ERR_DEV_MAIN)
    else $error("deviation excess not raised");

  dev_unit_a: assert property ( // [RQ5]
    idle_tick && mode_pos && !trip_homing && !trip_speed &&
      deviation_unit_select &&
      magnitude(feedback.dev_encoder) > deviation_excess_level
    |=> error_code.main == ERR_DEV_MAIN)
    else $error("encoder deviation not compared");

  range_trip_a: assert property ( // [RQ7]
    idle_tick && mode_pos && !trip_homing && !trip_speed && !trip_dev
      && magnitude(feedback.motor_revs) > working_range_revs
    |=> error_code.main == ERR_RANGE_MAIN)
    else $error("working range not raised");

  hybrid_trip_a: assert property ( // [RQ8]
    idle_tick && mode_full && !trip_homing && !trip_speed &&
      magnitude(hybrid_gap) > hybrid_deviation_level
    |=> error_code.main == ERR_HYBRID_MAIN)
    else $error("hybrid deviation not raised");

  homing_cut_a: assert property ( // [RQ9]
    homing_hit |=> drive_cut)
    else $error("homing error or current cut missing");

  homing_off_a: assert property ( // [RQ10]
    idle_tick && !homing_enable
    |=> !(error_code.valid && error_code.main == ERR_HOMING_MAIN))
    else $error("homing error raised while disabled");

  torque_clamp_a: assert property ( // [RQ12]
    clamp_pos && !current_off && !pos_travel_inhibit
    |=> torque_in_limit_out && torque_out == $past(limit_pos))
    else $error("torque clamp or in-limit wrong");

  travel_block_a: assert property ( // [RQ14]
    (pos_travel_inhibit && torque_command > 16'sh0000) ||
      (neg_travel_inhibit && torque_command < 16'sh0000)
    |=> torque_out == 16'sh0000)
    else $error("inhibited direction still driven");

  error_hold_a: assert property ( // [RQ15]
    error_code.valid && !alarm_clear |=> $stable(error_code))
    else $error("held error changed without clear");

  tick_space_a: assert property ( // [RQ15]
    tick |=> !tick [*2])
    else $error("control tick too frequent");

endmodule

// File: logic/servo_protection_pkg.sv
// constants, register map and carrier types of the servo protection monitor
// assumes a 50 MHz control clock and an AXI4-Lite register slave
package servo_protection_pkg;

  // clock and control cycle timing
  localparam int unsigned CLOCK_PERIOD_NS   = 20;
  localparam int unsigned CONTROL_PERIOD_NS = 125000;
  localparam int unsigned CONTROL_CYCLES    =
    CONTROL_PERIOD_NS / CLOCK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFF_CONTROL        = 8'h00;
  localparam logic [7:0] OFF_OVERSPEED      = 8'h04;
  localparam logic [7:0] OFF_DEV_EXCESS     = 8'h08;
  localparam logic [7:0] OFF_DEV_UNIT       = 8'h0C;
  localparam logic [7:0] OFF_RANGE_REVS     = 8'h10;
  localparam logic [7:0] OFF_HYBRID_DEV     = 8'h14;
  localparam logic [7:0] OFF_COMM_EXT_1     = 8'h18;
  localparam logic [7:0] OFF_TQ_LEVEL_1     = 8'h1C;
  localparam logic [7:0] OFF_TQ_SELECT      = 8'h20;
  localparam logic [7:0] OFF_TQ_LEVEL_2     = 8'h24;
  localparam logic [7:0] OFF_ERROR          = 8'h28;
  localparam logic [7:0] OFF_IRQ_STATUS     = 8'h2C;
  localparam logic [7:0] OFF_IRQ_MASK       = 8'h30;

  // field positions
  localparam int unsigned ALARM_CLEAR_BIT   = 0;
  localparam int unsigned HOMING_OT_BIT     = 7;
  localparam int unsigned ERROR_VALID_BIT   = 16;

  // event bit positions, shared by status and mask
  localparam int unsigned EV_SPEED   = 0;
  localparam int unsigned EV_DEV     = 1;
  localparam int unsigned EV_RANGE   = 2;
  localparam int unsigned EV_HYBRID  = 3;
  localparam int unsigned EV_HOMING  = 4;
  localparam int unsigned EV_TORQUE  = 5;
  localparam int unsigned EV_W       = 6;

  // values after reset
  localparam logic [31:0] OVERSPEED_DEFAULT  = 32'h0000_1B58;
  localparam logic [31:0] DEV_EXCESS_RESET   = 32'h0001_86A0;
  localparam logic [31:0] RANGE_REVS_RESET   = 32'h0000_000A;
  localparam logic [31:0] HYBRID_DEV_RESET   = 32'h0000_3E80;
  localparam logic [15:0] TQ_LEVEL_RESET     = 16'h01F4;
  localparam logic [15:0] TQ_SELECT_RESET    = 16'h0001;

  // error codes, main and sub number
  localparam logic [7:0] ERR_SPEED_MAIN  = 8'h1A;
  localparam logic [7:0] ERR_DEV_MAIN    = 8'h18;
  localparam logic [7:0] ERR_RANGE_MAIN  = 8'h22;
  localparam logic [7:0] ERR_HYBRID_MAIN = 8'h19;
  localparam logic [7:0] ERR_HOMING_MAIN = 8'h5E;
  localparam logic [3:0] ERR_SUB_ZERO    = 4'h0;
  localparam logic [3:0] ERR_HOMING_SUB  = 4'h3;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_POSITION,
    MODE_VELOCITY,
    MODE_TORQUE,
    MODE_FULL_CLOSED
  } control_mode_type;

  typedef struct packed {
    logic signed [31:0] speed;
    logic signed [31:0] dev_command;
    logic signed [31:0] dev_encoder;
    logic signed [31:0] motor_position;
    logic signed [31:0] load_position;
    logic signed [31:0] motor_revs;
  } feedback_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] main;
    logic [3:0] sub;
  } error_code_type;

  // absolute value, saturating the most negative input
  function automatic logic [31:0] magnitude(input logic signed [31:0] v);
    if (v == 32'sh8000_0000) begin
      magnitude = 32'h7FFF_FFFF;
    end else begin
      magnitude = v[31] ? 32'(-v) : 32'(v);
    end
  endfunction

endpackage

// File: logic/level_check.sv
// one protection comparison: magnitude of a signed quantity against a level
// assumes the caller samples the result on its control cycle tick
`timescale 1ns/1ns

module level_check
  import servo_protection_pkg::*;
(
  input  wire logic               enable,
  input  wire logic signed [31:0] value,
  input  wire logic        [31:0] level,
  output wire logic               exceeds
);

  // equal to the level is still inside the limit
  assign exceeds = enable && (magnitude(value) > level);

endmodule

// File: verif/encoder_scale_model.sv
// partner model: motor encoder, external scale and over-travel sensors
// assumes the bench sets targets just after a rising clock edge
`timescale 1ns/1ns

module encoder_scale_model
  import servo_protection_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire feedback_type target,
  input  wire logic [1:0]   sensors,
  output feedback_type      feedback,
  output logic              pos_travel_inhibit,
  output logic              neg_travel_inhibit
);
  // one clock of sampling delay, as a real feedback interface has
  always_ff @(posedge clock) begin
    if (reset) begin
      feedback           <= '0;
      pos_travel_inhibit <= 1'b0;
      neg_travel_inhibit <= 1'b0;
    end else begin
      feedback           <= target;
      pos_travel_inhibit <= sensors[1];
      neg_travel_inhibit <= sensors[0];
    end
  end
endmodule

// File: verif/servo_protection_monitor_bench.sv
// self-checking bench of the servo protection monitor
// assumes the package constants and a control cycle shortened to 8 clocks
`timescale 1ns/1ns

module servo_protection_monitor_bench
  import servo_protection_pkg::*;
();
  localparam int unsigned CYC = 8;
  logic               clock, reset, awvalid, wvalid, bready, arvalid, rready;
  logic               awready, wready, bvalid, arready, rvalid, irq;
  logic               homing_z_return, torque_in_limit_out, current_off;
  logic               pos_travel_inhibit, neg_travel_inhibit;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp, sensors;
  control_mode_type   control_mode;
  feedback_type       feedback, target;
  logic signed [15:0] torque_command, torque_out;
  error_code_type     error_code;
  int                 n_errors, comparisons, cycles;

  servo_protection_monitor #(.CYCLE_COUNT(CYC)) servo_protection_monitor_i (
    .clock(clock), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .control_mode(control_mode), .feedback(feedback),
    .homing_z_return(homing_z_return),
    .pos_travel_inhibit(pos_travel_inhibit),
    .neg_travel_inhibit(neg_travel_inhibit),
    .torque_command(torque_command), .torque_out(torque_out),
    .torque_in_limit_out(torque_in_limit_out), .current_off(current_off),
    .error_code(error_code), .irq(irq));

  encoder_scale_model encoder_scale_model_i (
    .clock(clock), .reset(reset), .target(target), .sensors(sensors),
    .feedback(feedback), .pos_travel_inhibit(pos_travel_inhibit),
    .neg_travel_inhibit(neg_travel_inhibit));

  function automatic logic [31:0] err(input logic [7:0] m, input logic [3:0] s);
    return {19'h0, 1'b1, m, s};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ready is read at the falling edge, so it is settled before the taking edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] resp);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done  = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge clock);
      aw_done = aw_done || awready;
      w_done  = w_done || wready;
      @(posedge clock);
      awvalid <= !aw_done;
      wvalid  <= !w_done;
    end
    do @(negedge clock); while (!bvalid);
    check(32'(bresp), 32'(resp));
    @(posedge clock);
  endtask

  task automatic read_check(input logic [7:0] a, input logic [31:0] want,
                            input logic [1:0] resp);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge clock); while (!arready);
    @(posedge clock);
    arvalid <= 1'b0;
    do @(negedge clock); while (!rvalid);
    check(rdata, want);
    check(32'(rresp), 32'(resp));
    @(posedge clock);
  endtask

  // two control cycles, so at least one tick has seen the new feedback
  task automatic settle(input logic [31:0] want_err, input logic want_irq);
    repeat (2 * CYC) @(posedge clock);
    @(negedge clock);
    check(32'(error_code), want_err);
    check(32'(irq), 32'(want_irq));
    @(posedge clock);
  endtask

  task automatic clear_alarm();
    target          <= '0;
    sensors         <= 2'b00;
    homing_z_return <= 1'b0;
    torque_command  <= 16'sh0;
    axi_write(OFF_CONTROL, 32'h1, RESP_OKAY);
    axi_write(OFF_IRQ_STATUS, 32'h3F, RESP_OKAY);
    settle(32'h0, 1'b0);
  endtask

  task automatic torque_step(input logic signed [15:0] cmd,
                             input logic [1:0] sens,
                             input logic [15:0] want, input logic lim);
    torque_command <= cmd;
    sensors        <= sens;
    repeat (3) @(negedge clock);
    check({16'h0, torque_out}, {16'h0, want});
    check(32'(torque_in_limit_out), 32'(lim));
    @(posedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    {reset, homing_z_return} = 2'b10;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, sensors} = '0;
    wstrb          = 4'hF;
    control_mode   = MODE_VELOCITY;
    target         = '0;
    torque_command = 16'sh0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    read_check(OFF_OVERSPEED, OVERSPEED_DEFAULT, RESP_OKAY);
    read_check(8'h80, 32'h0, RESP_SLVERR);
    axi_write(OFF_OVERSPEED, 32'h64, RESP_OKAY);
    target.speed <= -32'sh64;
    settle(32'h0, 1'b0);
    target.speed <= -32'sh65;
    settle(err(ERR_SPEED_MAIN, ERR_SUB_ZERO), 1'b0);
    axi_write(OFF_IRQ_MASK, 32'h3F, RESP_OKAY);
    target.speed <= 32'sh0;
    settle(err(ERR_SPEED_MAIN, ERR_SUB_ZERO), 1'b1);
    clear_alarm();
    $display("test over-speed done");
    control_mode <= MODE_POSITION;
    axi_write(OFF_DEV_EXCESS, 32'h100, RESP_OKAY);
    target.dev_command <= 32'sh50;
    target.dev_encoder <= -32'sh101;
    settle(32'h0, 1'b0);
    axi_write(OFF_DEV_UNIT, 32'h1, RESP_OKAY);
    settle(err(ERR_DEV_MAIN, ERR_SUB_ZERO), 1'b1);
    clear_alarm();
    axi_write(OFF_DEV_UNIT, 32'h0, RESP_OKAY);
    target.dev_command <= 32'sh101;
    settle(err(ERR_DEV_MAIN, ERR_SUB_ZERO), 1'b1);
    clear_alarm();
    $display("test deviation done");
    target.motor_revs <= 32'sh0A;
    settle(32'h0, 1'b0);
    target.motor_revs <= 32'sh0B;
    settle(err(ERR_RANGE_MAIN, ERR_SUB_ZERO), 1'b1);
    clear_alarm();
    control_mode <= MODE_FULL_CLOSED;
    target.motor_position <= 32'sh3E81;
    settle(err(ERR_HYBRID_MAIN, ERR_SUB_ZERO), 1'b1);
    clear_alarm();
    $display("test range and hybrid done");
    sensors         <= 2'b10;
    homing_z_return <= 1'b1;
    settle(32'h0, 1'b0);
    axi_write(OFF_COMM_EXT_1, 32'h80, RESP_OKAY);
    settle(err(ERR_HOMING_MAIN, ERR_HOMING_SUB), 1'b1);
    check(32'(current_off), 32'h1);
    axi_write(OFF_COMM_EXT_1, 32'h0, RESP_OKAY);
    clear_alarm();
    $display("test homing done");
    axi_write(OFF_TQ_LEVEL_1, 32'h100, RESP_OKAY);
    axi_write(OFF_TQ_SELECT, 32'h0, RESP_OKAY);
    torque_step(16'sh200, 2'b00, 16'h0100, 1'b1);
    torque_step(-16'sh200, 2'b00, 16'hFF00, 1'b1);
    torque_step(16'sh80, 2'b00, 16'h0080, 1'b0);
    torque_step(16'sh80, 2'b10, 16'h0000, 1'b0);
    torque_step(16'sh80, 2'b01, 16'h0080, 1'b0);
    torque_step(-16'sh80, 2'b01, 16'h0000, 1'b0);
    axi_write(OFF_TQ_SELECT, 32'h2, RESP_OKAY);
    torque_step(-16'sh200, 2'b00, 16'hFE0C, 1'b1);
    clear_alarm();
    $display("test torque done");
    print_verdict();
  end
endmodule
